// >>> logic/swpmc_pkg.sv
package swpmc_pkg;

  // ==========================================================
  // Register map, fields and reset values
  // ==========================================================
  localparam int NUM_PORTS = 5;
  localparam logic [7:0] IDX_GLOBAL_MODE = 8'h0e;
  localparam logic [7:0] IDX_IDLE_TIMEOUT = 8'h0f;
  localparam logic [7:0] IDX_PORT_CTL = 8'h1d;
  localparam logic [7:0] PORT_CTL_STRIDE = 8'h10;
  localparam logic [7:0] IDX_MIIM_CTL = 8'h70;
  localparam logic [7:0] MIIM_CTL_STRIDE = 8'h01;
  localparam logic [7:0] IDX_PM_STATUS = 8'h7f;
  localparam int MODE_LSB = 3;
  localparam int PORT_PD_BIT = 3;
  localparam int MIIM_PD_BIT = 11;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY = 2'h1;
  localparam logic [1:0] MODE_SOFT_DOWN = 2'h2;
  localparam logic [1:0] MODE_SAVE = 2'h3;
  localparam logic [7:0] GLOBAL_MODE_RST = 8'h00;
  localparam logic [7:0] IDLE_TIMEOUT_RST = 8'h10;
  localparam logic [7:0] PORT_CTL_RST = 8'h00;
  localparam logic [15:0] MIIM_CTL_RST = 16'h0000;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_WIDTH_NS = 120;
  localparam int PULSE_WIDTH_CYC =
    (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_NS = 1000000000;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLEEP_UNIT_NS = 1000000;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_NS / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYC = 4;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    CHIP_RUN,
    CHIP_SOFT_DOWN,
    CHIP_HW_DOWN,
    CHIP_RESET
  } swpmc_chip_e;

  typedef enum logic {
    ED_AWAKE,
    ED_SLEEP
  } swpmc_ed_e;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } swpmc_ahb_s;

  typedef struct packed {
    logic pll_en;
    logic host_if_en;
    logic mac_en;
    logic [4:0] phy_tx_en;
    logic [4:0] phy_rx_en;
    logic [4:0] rx_energy_only;
    logic [4:0] link_pulse;
  } swpmc_power_s;

endpackage : swpmc_pkg

// >>> logic/swpmc_power_ctrl.sv
// Functional notes
// R1 - Power-down pin low: chip off; release resets
// R2 - Mode field bits 4:3 select four modes
// R3 - Port control bit 3 powers down PHY
// R4 - Mode field reads 00 after reset
// R5 - Normal mode: clocks, PHY, MAC, host on
// R6 - Host may leave normal mode by writing
// R7 - Low-power state sends 120 ns pulses per second
// R8 - Low-power state keeps only receive energy detect
// R9 - Sleep after idle longer than timeout setting
// R10 - Energy in low-power state wakes the port
// R11 - Soft power-down stops clocks, PHYs and MACs
// R12 - Host access wakes soft power-down, resets registers
// R13 - Power saving needs autoneg, no cable, mode 11
// R14 - Power saving keeps clocks, MAC, host, transmitter
// R15 - Line activity restores receiver in power saving
// R16 - Host may leave power saving by writing
// R17 - PHY control bit 11 also powers down
// R18 - Mode acts after write; gating is registered
`timescale 1ns/1ps
module swpmc_power_ctrl #(
  parameter int PULSE_PERIOD_CYC = swpmc_pkg::PULSE_PERIOD_CYC,
  parameter int SLEEP_UNIT_CYC = swpmc_pkg::SLEEP_UNIT_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic chip_power_down_n_in,
  input wire logic [4:0] cable_energy_in,
  input wire logic [4:0] an_enable_in,
  input wire swpmc_pkg::swpmc_ahb_s ahb_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output swpmc_pkg::swpmc_power_s power_out,
  output logic chip_reset_out
);
  import swpmc_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  swpmc_chip_e chip_state;
  swpmc_ed_e ed_state [NUM_PORTS];
  logic [2:0] rst_cnt;
  logic [7:0] global_mode;
  logic [7:0] idle_timeout;
  logic [7:0] port_ctl [NUM_PORTS];
  logic [15:0] miim_ctl [NUM_PORTS];
  logic [7:0] idle_cnt [NUM_PORTS];
  logic [31:0] unit_cnt;
  logic [31:0] pulse_cnt;
  logic [4:0] psave_q;
  logic [4:0] ed_sleep;
  logic [4:0] pd_mask;
  logic [1:0] mode;
  logic soft_rst;
  logic acc;
  logic map_ok;
  logic [7:0] acc_idx;
  logic [31:0] rd_data;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic tick;
  logic pulse_on;
  logic on;

  function automatic logic [2:0] port_hit(
    input logic [7:0] idx,
    input logic [7:0] base,
    input logic [7:0] step
  );
    logic [2:0] hit;
    hit = 3'h7;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (idx == 8'(base + 8'(p) * step))
      begin
        hit = 3'(p);
      end
    end
    return hit;
  endfunction : port_hit

  // ==========================================================
  // Decode
  // ==========================================================
  // R2 mode field decode
  assign mode = global_mode[MODE_LSB +: 2];
  assign soft_rst = (chip_state == CHIP_HW_DOWN) ||
                    (chip_state == CHIP_RESET);
  assign on = (chip_state == CHIP_RUN);
  assign acc = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
  assign map_ok = (ahb_in.haddr[31:10] == 22'h00_0000) &&
                  (ahb_in.haddr[1:0] == 2'h0);
  assign acc_idx = ahb_in.haddr[9:2];
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      // R3 port power-down bit
      // R17 alternate PHY power-down
      pd_mask[p] = port_ctl[p][PORT_PD_BIT] | miim_ctl[p][MIIM_PD_BIT];
      ed_sleep[p] = (ed_state[p] == ED_SLEEP);
    end
  end

  always_comb
  begin
    logic [2:0] rp;
    logic [2:0] mp;
    rp = port_hit(acc_idx, IDX_PORT_CTL, PORT_CTL_STRIDE);
    mp = port_hit(acc_idx, IDX_MIIM_CTL, MIIM_CTL_STRIDE);
    rd_data = 32'h0000_0000;
    if (!map_ok)
    begin
      rd_data = 32'h0000_0000;
    end
    else if (acc_idx == IDX_GLOBAL_MODE)
    begin
      rd_data = {24'h00_0000, global_mode};
    end
    else if (acc_idx == IDX_IDLE_TIMEOUT)
    begin
      rd_data = {24'h00_0000, idle_timeout};
    end
    else if (rp != 3'h7)
    begin
      rd_data = {24'h00_0000, port_ctl[rp]};
    end
    else if (mp != 3'h7)
    begin
      rd_data = {16'h0000, miim_ctl[mp]};
    end
    else if (acc_idx == IDX_PM_STATUS)
    begin
      rd_data = {17'h0_0000, pd_mask, psave_q, ed_sleep};
    end
  end

  // ==========================================================
  // Bus slave
  // ==========================================================
  // Reads are answered with no wait state, so the data is taken
  // from the address phase and held in a flop for the data phase.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      if (ahb_in.hready)
      begin
        wr_pend <= acc && ahb_in.hwrite && map_ok;
        wr_idx <= acc_idx;
      end
      if (acc && !ahb_in.hwrite)
      begin
        hrdata_out <= rd_data;
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      global_mode <= GLOBAL_MODE_RST;
      idle_timeout <= IDLE_TIMEOUT_RST;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        port_ctl[p] <= PORT_CTL_RST;
        miim_ctl[p] <= MIIM_CTL_RST;
      end
    end
    else if (ce_in)
    begin
      if (soft_rst)
      begin
        // R4 mode resets normal
        // R12 registers to defaults
        global_mode <= GLOBAL_MODE_RST;
        idle_timeout <= IDLE_TIMEOUT_RST;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
          port_ctl[p] <= PORT_CTL_RST;
          miim_ctl[p] <= MIIM_CTL_RST;
        end
      end
      else if (wr_pend && on)
      begin
        // R6 host selects mode
        // R16 leave power saving
        if (wr_idx == IDX_GLOBAL_MODE)
        begin
          global_mode <= ahb_in.hwdata[7:0];
        end
        else if (wr_idx == IDX_IDLE_TIMEOUT)
        begin
          idle_timeout <= ahb_in.hwdata[7:0];
        end
        for (int p = 0; p < NUM_PORTS; p++)
        begin
          if (wr_idx == 8'(IDX_PORT_CTL + 8'(p) * PORT_CTL_STRIDE))
          begin
            port_ctl[p] <= ahb_in.hwdata[7:0];
          end
          if (wr_idx == 8'(IDX_MIIM_CTL + 8'(p) * MIIM_CTL_STRIDE))
          begin
            miim_ctl[p] <= ahb_in.hwdata[15:0];
          end
        end
      end
    end
  end

  // ==========================================================
  // Chip power state
  // ==========================================================
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      chip_state <= CHIP_RUN;
      rst_cnt <= 3'h0;
    end
    else if (ce_in)
    begin
      if (!chip_power_down_n_in)
      begin
        // R1 hardware power-down
        chip_state <= CHIP_HW_DOWN;
      end
      else
      begin
        case (chip_state)
          CHIP_RUN:
          begin
            // R11 enter soft power-down
            if (mode == MODE_SOFT_DOWN)
            begin
              chip_state <= CHIP_SOFT_DOWN;
            end
          end
          CHIP_SOFT_DOWN:
          begin
            // R12 access wakes chip
            if (acc)
            begin
              chip_state <= CHIP_RESET;
              rst_cnt <= 3'(RESET_HOLD_CYC - 1);
            end
          end
          CHIP_HW_DOWN:
          begin
            // R1 release resets chip
            chip_state <= CHIP_RESET;
            rst_cnt <= 3'(RESET_HOLD_CYC - 1);
          end
          CHIP_RESET:
          begin
            if (rst_cnt == 3'h0)
            begin
              chip_state <= CHIP_RUN;
            end
            else
            begin
              rst_cnt <= rst_cnt - 3'h1;
            end
          end
          default:
          begin
            chip_state <= CHIP_RUN;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Energy detect and power saving
  // ==========================================================
  assign tick = (unit_cnt == 32'(SLEEP_UNIT_CYC - 1));
  assign pulse_on = (pulse_cnt < 32'(PULSE_WIDTH_CYC));

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      unit_cnt <= 32'h0000_0000;
      pulse_cnt <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      unit_cnt <= (tick || mode != MODE_ENERGY) ? 32'h0000_0000
                                                : unit_cnt + 32'h1;
      // R7 one pulse per second
      if (pulse_cnt == 32'(PULSE_PERIOD_CYC - 1))
      begin
        pulse_cnt <= 32'h0000_0000;
      end
      else
      begin
        pulse_cnt <= pulse_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        ed_state[p] <= ED_AWAKE;
        idle_cnt[p] <= 8'h00;
      end
    end
    else if (ce_in)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        if (mode != MODE_ENERGY || !on)
        begin
          ed_state[p] <= ED_AWAKE;
          idle_cnt[p] <= 8'h00;
        end
        else if (cable_energy_in[p])
        begin
          // R10 energy wakes port
          ed_state[p] <= ED_AWAKE;
          idle_cnt[p] <= 8'h00;
        end
        else
        begin
          if (tick && idle_cnt[p] != 8'hff)
          begin
            idle_cnt[p] <= idle_cnt[p] + 8'h01;
          end
          // R9 idle timeout sleep
          if (idle_cnt[p] > idle_timeout)
          begin
            ed_state[p] <= ED_SLEEP;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      psave_q <= 5'h00;
    end
    else if (ce_in)
    begin
      // R13 power saving entry
      // R15 activity restores receiver
      psave_q <= (on && mode == MODE_SAVE) ?
                 (an_enable_in & ~cable_energy_in) : 5'h00;
    end
  end

  // ==========================================================
  // Power enables
  // ==========================================================
  // Every enable comes from a flop, so a clock gate fed by it only
  // sees a change just after an edge and cannot cut a clock pulse.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      power_out <= '0;
      chip_reset_out <= 1'b0;
    end
    else if (ce_in)
    begin
      chip_reset_out <= soft_rst;
      // R18 registered clock gating
      // R5 normal keeps all on
      // R14 power saving keeps core
      power_out.pll_en <= on && !(mode == MODE_ENERGY && &ed_sleep);
      power_out.host_if_en <= on && !(mode == MODE_ENERGY && &ed_sleep);
      power_out.mac_en <= on && !(mode == MODE_ENERGY && &ed_sleep);
      // R11 PHYs off
      power_out.phy_tx_en <= on ? (~pd_mask & ~ed_sleep) : 5'h00;
      power_out.phy_rx_en <= on ? (~pd_mask & ~ed_sleep & ~psave_q)
                                : 5'h00;
      // R8 only energy detect
      power_out.rx_energy_only <= on ? (~pd_mask & ed_sleep) : 5'h00;
      // R7 sleep link pulses
      power_out.link_pulse <= (on && pulse_on) ? (~pd_mask & ed_sleep)
                                               : 5'h00;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_pin_down;
    ce_in && !chip_power_down_n_in ##1 ce_in;
  endsequence
  sequence s_wake;
    ce_in && chip_state == CHIP_SOFT_DOWN && acc && chip_power_down_n_in;
  endsequence

  property p_hw_down;
    s_pin_down |=> !power_out.pll_en && power_out.phy_tx_en == 5'h00;
  endproperty
  a_hw_down: assert property (p_hw_down) // R1
    else $error("chip still powered with pin low");

  property p_release;
    ce_in && chip_state == CHIP_HW_DOWN && chip_power_down_n_in
      |=> chip_state == CHIP_RESET ##0 chip_reset_out;
  endproperty
  a_release: assert property (p_release) // R1
    else $error("no internal reset after pin release");

  property p_reset_mode;
    ce_in && chip_state == CHIP_RESET |=> mode == MODE_NORMAL;
  endproperty
  a_reset_mode: assert property (p_reset_mode) // R4
    else $error("mode not normal after reset");

  property p_normal_on;
    ce_in && on && mode == MODE_NORMAL
      |=> power_out.pll_en && power_out.mac_en && power_out.host_if_en;
  endproperty
  a_normal_on: assert property (p_normal_on) // R5
    else $error("normal mode block disabled");

  property p_soft_down;
    ce_in && on && mode == MODE_SOFT_DOWN && chip_power_down_n_in
      ##1 ce_in |=> !power_out.pll_en && power_out.phy_rx_en == 5'h00;
  endproperty
  a_soft_down: assert property (p_soft_down) // R11
    else $error("soft power-down left clocks on");

  property p_wake;
    s_wake |=> chip_state == CHIP_RESET ##1 global_mode == GLOBAL_MODE_RST;
  endproperty
  a_wake: assert property (p_wake) // R12
    else $error("host access did not wake and reset");

  property p_sleep;
    ce_in && on && mode == MODE_ENERGY && !cable_energy_in[0] &&
      idle_cnt[0] > idle_timeout |=> ed_sleep[0];
  endproperty
  a_sleep: assert property (p_sleep) // R9
    else $error("port did not sleep after idle timeout");

  property p_ed_wake;
    ce_in && ed_sleep[0] && cable_energy_in[0] |=> !ed_sleep[0];
  endproperty
  a_ed_wake: assert property (p_ed_wake) // R10
    else $error("energy did not wake port");

  property p_pulse_width;
    $rose(pulse_on) |-> pulse_on [*5];
  endproperty
  a_pulse_width: assert property (p_pulse_width) // R7
    else $error("link pulse shorter than its width");

  property p_port_pd;
    ce_in && pd_mask[0] |=> !power_out.phy_tx_en[0] &&
      !power_out.phy_rx_en[0];
  endproperty
  a_port_pd: assert property (p_port_pd) // R3
    else $error("powered-down PHY still enabled");

  property p_psave;
    ce_in && !(mode == MODE_SAVE) ##1 ce_in
      |=> power_out.phy_rx_en == power_out.phy_tx_en;
  endproperty
  a_psave: assert property (p_psave) // R13
    else $error("receiver off outside power saving");

endmodule : swpmc_power_ctrl

// >>> tb/swpmc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host processor model on the register bus
// ==========================================================
module swpmc_host_model (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output swpmc_pkg::swpmc_ahb_s ahb_out
);
  import swpmc_pkg::*;

  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;

  assign ahb_out = {hsel, haddr, htrans, hwrite, hsize, hwdata, hready_in};

  // host bus transfers, read or write
  // Called just after a rising edge. Released buses carry the inverse of
  // their last value so that a stale word is never read as a live one.
  task automatic xfer(input logic wr, input logic [31:0] addr,
    input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~addr;
    hwdata <= wd;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    rd = hrdata_in;
    hwdata <= ~wd;
  endtask : xfer
endmodule : swpmc_host_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import swpmc_pkg::*;

  localparam int PERIOD = 40;
  localparam int UNIT = 4;
  localparam swpmc_power_s NORM = '{1'b1, 1'b1, 1'b1, 5'h1f, 5'h1f,
    5'h00, 5'h00};

  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic chip_power_down_n_in = 1'b1;
  logic [4:0] cable_energy_in = 5'h1f;
  logic [4:0] an_enable_in = 5'h00;
  swpmc_ahb_s ahb;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  swpmc_power_s pwr;
  logic chip_reset;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rdv;

  swpmc_power_ctrl #(.PULSE_PERIOD_CYC(PERIOD), .SLEEP_UNIT_CYC(UNIT))
  swpmc_power_ctrl_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .ce_in(ce_in), .chip_power_down_n_in(chip_power_down_n_in),
    .cable_energy_in(cable_energy_in), .an_enable_in(an_enable_in),
    .ahb_in(ahb), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .power_out(pwr), .chip_reset_out(chip_reset));

  swpmc_host_model swpmc_host_model_inst (.clk_in(clk_in),
    .hready_in(hready), .hrdata_in(hrdata), .ahb_out(ahb));

  initial
  begin
    forever #(CLK_PERIOD_NS / 2.0) clk_in = ~clk_in;
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  function automatic logic [31:0] ra(input logic [7:0] idx);
    return {22'h00_0000, idx, 2'h0};
  endfunction : ra

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    @(posedge clk_in);
    swpmc_host_model_inst.xfer(1'b1, ra(idx), d, x);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge clk_in);
    swpmc_host_model_inst.xfer(1'b0, ra(idx), 32'h0000_0000, rdv);
    chk(hresp, 1'b0);
    chk(hready, 1'b1);
  endtask : rd

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic test_reset();
    chk(32'(pwr), 32'(NORM));
    rd(IDX_GLOBAL_MODE);
    chk(rdv, 32'h0000_0000);
    rd(IDX_IDLE_TIMEOUT);
    chk(rdv, 32'(IDLE_TIMEOUT_RST));
    wr(8'hc0, 32'hffff_ffff);
    rd(8'hc0);
    chk(rdv, 32'h0000_0000);
    // A frozen block must ignore the pin until it runs again.
    @(posedge clk_in);
    ce_in <= 1'b0;
    chip_power_down_n_in <= 1'b0;
    cyc(4);
    chk(32'(pwr), 32'(NORM));
    @(posedge clk_in);
    chip_power_down_n_in <= 1'b1;
    ce_in <= 1'b1;
    $display("test reset done");
  endtask : test_reset

  task automatic test_port_pd();
    logic [4:0] m;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      m = ~(5'h01 << p);
      wr(IDX_PORT_CTL + PORT_CTL_STRIDE * 8'(p), 32'h0000_0008);
      cyc(3);
      chk(pwr.phy_tx_en, m);
      chk(pwr.phy_rx_en, m);
      rd(IDX_PORT_CTL + PORT_CTL_STRIDE * 8'(p));
      chk(rdv, 32'h0000_0008);
      wr(IDX_PORT_CTL + PORT_CTL_STRIDE * 8'(p), 32'h0000_0000);
      wr(IDX_MIIM_CTL + 8'(p), 32'h0000_0800);
      cyc(3);
      chk(pwr.phy_tx_en, m);
      wr(IDX_MIIM_CTL + 8'(p), 32'h0000_0000);
    end
    cyc(3);
    chk(32'(pwr), 32'(NORM));
    $display("test port power-down done");
  endtask : test_port_pd

  task automatic test_energy();
    int n;
    int k;
    wr(IDX_IDLE_TIMEOUT, 32'h0000_0002);
    wr(IDX_GLOBAL_MODE, 32'h0000_0008);
    @(posedge clk_in);
    cable_energy_in <= 5'h1e;
    cyc(5);
    chk(pwr.rx_energy_only, 5'h00);
    for (int i = 0; i < 60 && pwr.rx_energy_only[0] !== 1'b1; i++)
      @(negedge clk_in);
    chk(pwr.rx_energy_only, 5'h01);
    // Skip a pulse already under way so a whole one is measured.
    for (int i = 0; i < 2 * PERIOD && pwr.link_pulse[0] !== 1'b0; i++)
      @(negedge clk_in);
    for (int i = 0; i < 2 * PERIOD && pwr.link_pulse[0] !== 1'b1; i++)
      @(negedge clk_in);
    n = 0;
    k = 0;
    for (; n < 100 && pwr.link_pulse[0] === 1'b1; n++)
      @(negedge clk_in);
    for (; k < 100 && pwr.link_pulse[0] !== 1'b1; k++)
      @(negedge clk_in);
    chk(n, PULSE_WIDTH_CYC);
    chk(n + k, PERIOD);
    @(posedge clk_in);
    cable_energy_in <= 5'h00;
    for (int i = 0; i < 100 && pwr.pll_en !== 1'b0; i++)
      @(negedge clk_in);
    chk({pwr.pll_en, pwr.mac_en, pwr.host_if_en}, 3'h0);
    chk(pwr.rx_energy_only, 5'h1f);
    @(posedge clk_in);
    cable_energy_in <= 5'h1f;
    for (int i = 0; i < 20 && pwr.rx_energy_only !== 5'h00; i++)
      @(negedge clk_in);
    cyc(2);
    chk(32'(pwr), 32'(NORM));
    rd(IDX_GLOBAL_MODE);
    chk(rdv, 32'h0000_0008);
    wr(IDX_GLOBAL_MODE, 32'h0000_0000);
    $display("test energy detect done");
  endtask : test_energy

  task automatic test_saving();
    @(posedge clk_in);
    an_enable_in <= 5'h01;
    cable_energy_in <= 5'h1a;
    cyc(5);
    chk(pwr.phy_rx_en, 5'h1f);
    wr(IDX_GLOBAL_MODE, 32'h0000_0018);
    for (int i = 0; i < 20 && pwr.phy_rx_en[0] !== 1'b0; i++)
      @(negedge clk_in);
    chk(pwr.phy_rx_en, 5'h1e);
    chk(pwr.phy_tx_en, 5'h1f);
    chk({pwr.pll_en, pwr.mac_en, pwr.host_if_en}, 3'h7);
    rd(IDX_IDLE_TIMEOUT);
    chk(rdv, 32'h0000_0002);
    @(posedge clk_in);
    cable_energy_in <= 5'h1b;
    for (int i = 0; i < 20 && pwr.phy_rx_en[0] !== 1'b1; i++)
      @(negedge clk_in);
    chk(pwr.phy_rx_en, 5'h1f);
    wr(IDX_GLOBAL_MODE, 32'h0000_0000);
    rd(IDX_GLOBAL_MODE);
    chk(rdv, 32'h0000_0000);
    @(posedge clk_in);
    an_enable_in <= 5'h00;
    cable_energy_in <= 5'h1f;
    $display("test power saving done");
  endtask : test_saving

  task automatic test_soft();
    wr(IDX_IDLE_TIMEOUT, 32'h0000_0033);
    wr(IDX_GLOBAL_MODE, 32'h0000_0010);
    for (int i = 0; i < 20 && pwr.pll_en !== 1'b0; i++)
      @(negedge clk_in);
    chk({pwr.pll_en, pwr.mac_en}, 2'h0);
    chk({pwr.phy_tx_en, pwr.phy_rx_en}, 10'h000);
    rd(IDX_GLOBAL_MODE);
    for (int i = 0; i < 40 && !(pwr.pll_en === 1'b1 &&
      chip_reset === 1'b0); i++)
      @(negedge clk_in);
    chk(32'(pwr), 32'(NORM));
    rd(IDX_IDLE_TIMEOUT);
    chk(rdv, 32'(IDLE_TIMEOUT_RST));
    rd(IDX_GLOBAL_MODE);
    chk(rdv, 32'h0000_0000);
    $display("test soft power-down done");
  endtask : test_soft

  task automatic test_hwdown();
    wr(IDX_IDLE_TIMEOUT, 32'h0000_0044);
    @(posedge clk_in);
    chip_power_down_n_in <= 1'b0;
    for (int i = 0; i < 10 && chip_reset !== 1'b1; i++)
      @(negedge clk_in);
    cyc(2);
    chk({chip_reset, pwr.pll_en, pwr.mac_en, pwr.host_if_en}, 4'h8);
    chk(pwr.phy_tx_en, 5'h00);
    cyc(10);
    @(posedge clk_in);
    chip_power_down_n_in <= 1'b1;
    cyc(2);
    chk(chip_reset, 1'b1);
    for (int i = 0; i < 20 && !(pwr.pll_en === 1'b1 &&
      chip_reset === 1'b0); i++)
      @(negedge clk_in);
    chk(32'(pwr), 32'(NORM));
    rd(IDX_IDLE_TIMEOUT);
    chk(rdv, 32'(IDLE_TIMEOUT_RST));
    $display("test hardware power-down done");
  endtask : test_hwdown

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial
  begin
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    cyc(3);
    test_reset();
    test_port_pd();
    test_energy();
    test_saving();
    test_soft();
    test_hwdown();
    stop_test();
  end

  // The whole run needs a few hundred cycles; some fifty times that is a hang.
  initial
  begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    stop_test();
  end
endmodule : tb
